// >>> logic/encdg_top.sv
// counter wrap flags and open-circuit diagnostics of one encoder channel
//
// Contract
// - Set underflow when a down count wraps from reset value to limit.
// - Clear underflow once the counter drops below reset + 2/3 of the span.
// - Set overflow when an up count wraps from limit value to reset value.
// - Clear overflow once the counter rises above reset + 1/3 of the span.
// - Default limits span the full width, wrapping all-ones to zero.
// - Faults are detected only on enabled inputs in differential mode.
// - A low differential indication on an enabled input is a fault.
// - The group flag is high while any enabled input is faulty.
// - The data-invalid flag is high while an open-circuit fault exists.
// - Each input has its own fault flag, high while that input is faulty.
// - The track A indicator is green on a true level and red on a fault.
// - Fault flags are live, not latched, and may drop on a broken wire.
`default_nettype none
module encdg_top
    import encdg_pkg::*;
(
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              nrst_i,
    input  wire logic              ce_i,
    // channel selection
    input  wire logic              chan_idx_i,
    input  wire logic              chan_sel_i,
    // counter
    input  wire logic [CNT_W-1:0]  count_i,
    input  wire logic              count_valid_i,
    input  wire logic              count_up_i,
    input  wire encdg_range_t      range_i,
    // encoder tracks
    input  wire encdg_detect_cfg_t detect_cfg_i,
    input  wire logic [NUM_TRK-1:0] diff_low_i,
    input  wire logic [NUM_TRK-1:0] track_level_i,
    // status
    output logic                   underflow_o,
    output logic                   overflow_o,
    output logic                   open_circuit_o,
    output logic                   data_invalid_o,
    output logic [NUM_TRK-1:0]     track_fault_o,
    output encdg_led_t             track_a_indicator_led_o
);
    // ---------------------------------------------------------------
    // thresholds
    // ---------------------------------------------------------------
    function automatic logic [CNT_W-1:0] frac_point(
        input logic [CNT_W-1:0] lim,
        input logic [CNT_W-1:0] rst,
        input logic [1:0]       num
    );
        logic [CNT_W+1:0] prod;
        prod = ({2'h0, lim - rst} * {{CNT_W{1'b0}}, num}) /
               {{CNT_W{1'b0}}, THIRD_DIV};
        frac_point = prod[CNT_W-1:0] + rst;
    endfunction

    logic [CNT_W-1:0] under_thr;
    logic [CNT_W-1:0] over_thr;
    assign under_thr = frac_point(range_i.limit_value, range_i.reset_value,
                                  UNDER_NUM);
    assign over_thr  = frac_point(range_i.limit_value, range_i.reset_value,
                                  OVER_NUM);

    // ---------------------------------------------------------------
    // wrap flags
    // ---------------------------------------------------------------
    logic             active;
    logic [CNT_W-1:0] prev_reg;
    logic [CNT_W-1:0] prev_next;
    logic             prev_ok_reg;
    logic             prev_ok_next;
    logic             under_reg;
    logic             under_next;
    logic             over_reg;
    logic             over_next;
    logic             wrap_dn;
    logic             wrap_up;

    assign active = ce_i && chan_sel_i == chan_idx_i;

    // with default limits this is the ..00 to ..FF wrap and back
    assign wrap_dn = prev_ok_reg && !count_up_i &&
                     prev_reg == range_i.reset_value &&
                     count_i == range_i.limit_value;
    assign wrap_up = prev_ok_reg && count_up_i &&
                     prev_reg == range_i.limit_value &&
                     count_i == range_i.reset_value;

    always_comb begin
        prev_next    = prev_reg;
        prev_ok_next = prev_ok_reg;
        under_next   = under_reg;
        over_next    = over_reg;
        if (active && count_valid_i) begin
            prev_next    = count_i;
            prev_ok_next = 1'b1;
            // a fresh wrap wins over the hysteresis clear
            if (wrap_dn) begin
                under_next = 1'b1;
            end else if (under_reg && count_i < under_thr) begin
                under_next = 1'b0;
            end
            if (wrap_up) begin
                over_next = 1'b1;
            end else if (over_reg && count_i > over_thr) begin
                over_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_reg    <= RESET_DEFAULT;
            prev_ok_reg <= 1'b0;
            under_reg   <= 1'b0;
            over_reg    <= 1'b0;
        end else begin
            prev_reg    <= prev_next;
            prev_ok_reg <= prev_ok_next;
            under_reg   <= under_next;
            over_reg    <= over_next;
        end
    end

    // ---------------------------------------------------------------
    // open-circuit detection
    // ---------------------------------------------------------------
    logic [NUM_TRK-1:0] trk_fault;
    encdg_led_t         trk_led [NUM_TRK];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TRK; gi++) begin : g_trk
            encdg_track_fault u_trk (
                .clock_i    (clock_i),
                .nrst_i     (nrst_i),
                .ce_i       (active),
                .enable_i   (detect_cfg_i.differential &&
                             detect_cfg_i.detect_en[gi]),
                .diff_low_i (diff_low_i[gi]),
                .level_i    (track_level_i[gi]),
                .fault_o    (trk_fault[gi]),
                .led_o      (trk_led[gi])
            );
        end
    endgenerate

    // group flags registered once more so all open-circuit outputs line up; the wrap flags have one register stage less
    logic               group_reg;
    logic               group_next;
    logic               invalid_reg;
    logic               invalid_next;
    logic [NUM_TRK-1:0] fault_reg;
    logic [NUM_TRK-1:0] fault_next;
    encdg_led_t         led_reg;
    encdg_led_t         led_next;

    always_comb begin
        group_next   = group_reg;
        invalid_next = invalid_reg;
        fault_next   = fault_reg;
        led_next     = led_reg;
        if (active) begin
            fault_next   = trk_fault;
            group_next   = |trk_fault;
            invalid_next = |trk_fault;
            led_next     = trk_led[TRK_A];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            group_reg   <= 1'b0;
            invalid_reg <= 1'b0;
            fault_reg   <= '0;
            led_reg     <= ENCDG_LED_OFF;
        end else begin
            group_reg   <= group_next;
            invalid_reg <= invalid_next;
            fault_reg   <= fault_next;
            led_reg     <= led_next;
        end
    end

    assign underflow_o             = under_reg;
    assign overflow_o              = over_reg;
    assign open_circuit_o          = group_reg;
    assign data_invalid_o          = invalid_reg;
    assign track_fault_o           = fault_reg;
    assign track_a_indicator_led_o = led_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_wrap_dn;
        active && count_valid_i && wrap_dn;
    endsequence
    sequence s_wrap_up;
        active && count_valid_i && wrap_up;
    endsequence

    a_under_set: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_wrap_dn |=> under_reg)
        else $error("underflow not set on down wrap");
    a_under_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        active && count_valid_i && !wrap_dn && count_i < under_thr
        |=> !under_reg)
        else $error("underflow not cleared below threshold");
    a_over_set: assert property (@(posedge clock_i) disable iff (!nrst_i)
        s_wrap_up |=> over_reg)
        else $error("overflow not set on up wrap");
    a_over_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
        active && count_valid_i && !wrap_up && count_i > over_thr
        |=> !over_reg)
        else $error("overflow not cleared above threshold");
    a_group_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
        active && ce_i && detect_cfg_i.differential &&
        detect_cfg_i.detect_en[TRK_B] && diff_low_i[TRK_B]
        ##1 active |=> open_circuit_o && track_fault_o[TRK_B])
        else $error("group flag missing for faulty track");
    a_invalid_match: assert property (@(posedge clock_i) disable iff (!nrst_i)
        data_invalid_o == open_circuit_o)
        else $error("data invalid differs from open circuit");
    a_led_red: assert property (@(posedge clock_i) disable iff (!nrst_i)
        track_fault_o[TRK_A]
        |-> track_a_indicator_led_o == ENCDG_LED_RED)
        else $error("track A led not red on fault");
    a_sel_freeze: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !active |=> $stable(under_reg) && $stable(over_reg))
        else $error("flags changed on unselected channel");
endmodule
`default_nettype wire

// >>> common/encdg_pkg.sv
// package for the encoder counter diagnostics block
`default_nettype none
package encdg_pkg;
    // ---------------------------------------------------------------
    // widths and defaults
    // ---------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int NUM_TRK = 3;
    localparam logic [CNT_W-1:0] LIMIT_DEFAULT = 32'hFFFFFFFF;
    localparam logic [CNT_W-1:0] RESET_DEFAULT = 32'h00000000;
    localparam logic [1:0] THIRD_DIV = 2'h3;
    localparam logic [1:0] UNDER_NUM = 2'h2;
    localparam logic [1:0] OVER_NUM = 2'h1;
    // track indices
    localparam int TRK_A = 0;
    localparam int TRK_B = 1;
    localparam int TRK_C = 2;

    typedef struct packed {
        logic [CNT_W-1:0] limit_value;
        logic [CNT_W-1:0] reset_value;
    } encdg_range_t;

    typedef struct packed {
        logic                    differential;
        logic [NUM_TRK-1:0]      detect_en;
    } encdg_detect_cfg_t;

    typedef enum logic [1:0] {
        ENCDG_LED_OFF,
        ENCDG_LED_GREEN,
        ENCDG_LED_RED
    } encdg_led_t;
endpackage
`default_nettype wire

// >>> logic/encdg_track_fault.sv
// per-track open-circuit fault detection for one encoder input
`default_nettype none
module encdg_track_fault
    import encdg_pkg::*;
(
    // clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    // track input
    input  wire logic enable_i,
    input  wire logic diff_low_i,
    input  wire logic level_i,
    // status
    output logic      fault_o,
    output encdg_led_t led_o
);
    logic       fault_reg;
    logic       fault_next;
    encdg_led_t led_reg;
    encdg_led_t led_next;

    // live, not latched: follows the comparator every cycle that ce_i is high
    always_comb begin
        fault_next = fault_reg;
        led_next   = led_reg;
        if (ce_i) begin
            fault_next = enable_i && diff_low_i;
            if (fault_next) begin
                led_next = ENCDG_LED_RED;
            end else if (level_i) begin
                led_next = ENCDG_LED_GREEN;
            end else begin
                led_next = ENCDG_LED_OFF;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fault_reg <= 1'b0;
            led_reg   <= ENCDG_LED_OFF;
        end else begin
            fault_reg <= fault_next;
            led_reg   <= led_next;
        end
    end

    assign fault_o = fault_reg;
    assign led_o   = led_reg;

    a_fault_follows: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && enable_i && diff_low_i |=> fault_reg)
        else $error("fault not raised on low differential input");
    a_disabled_quiet: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && !enable_i |=> !fault_reg)
        else $error("fault raised on disabled input");
endmodule
`default_nettype wire

// >>> tb/encdg_enc_model.sv
// behavioural encoder with breakable differential track pairs
`default_nettype none
module encdg_enc_model
    import encdg_pkg::*;
(
    // clock
    input  wire logic               clock_i,
    // fault injection
    input  wire logic [NUM_TRK-1:0] broken_i,
    // tracks
    output logic      [NUM_TRK-1:0] diff_low_o,
    output logic      [NUM_TRK-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]         phase_reg = 4'h0;
    logic [NUM_TRK-1:0] quad;
    assign quad = {phase_reg == 4'hF, phase_reg[3] ^ phase_reg[2], phase_reg[3]};
    initial begin
        diff_low_o = '0;
        level_o = '0;
    end
    always @(posedge clock_i) begin
        phase_reg <= phase_reg + 4'h1;
        // open or shorted pair has no real level, so it toggles
        level_o <= (broken_i & ~level_o) | (~broken_i & quad);
        diff_low_o <= broken_i;
    end
endmodule
`default_nettype wire

// >>> tb/tb_encdg_top.sv
// self-checking bench for the encoder counter diagnostics block
`default_nettype none
module tb_encdg_top
    import encdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock_i = 1'b0;
    logic              nrst_i = 1'b0;
    logic              ce_i = 1'b1;
    logic              sel = 1'b1;
    logic              valid = 1'b1;
    logic              up = 1'b0;
    logic [CNT_W-1:0]  cnt = '0;
    encdg_range_t      rng = {LIMIT_DEFAULT, RESET_DEFAULT};
    encdg_detect_cfg_t cfg = '0;
    logic [NUM_TRK-1:0] brk = '0;
    logic [NUM_TRK-1:0] dlow, lvl, flt;
    logic              uf, of, oc, inv;
    encdg_led_t        led;
    int                error_cnt = 0;
    int                check_count = 0;

    always #4 clock_i = ~clock_i;

    encdg_enc_model i_enc (.clock_i(clock_i), .broken_i(brk),
        .diff_low_o(dlow), .level_o(lvl));
    encdg_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .chan_idx_i(1'b1), .chan_sel_i(sel), .count_i(cnt),
        .count_valid_i(valid), .count_up_i(up), .range_i(rng),
        .detect_cfg_i(cfg), .diff_low_i(dlow), .track_level_i(lvl),
        .underflow_o(uf), .overflow_o(of), .open_circuit_o(oc),
        .data_invalid_o(inv), .track_fault_o(flt),
        .track_a_indicator_led_o(led));

    // ---------------------------------------------------------------
    // compare and report
    // ---------------------------------------------------------------
    task automatic chk(input logic e, input logic a, input string m);
        check_count++;
        if (a !== e) begin
            error_cnt++;
            $display("ERROR %0t %s: exp %b got %b", $time, m, e, a);
        end
    endtask
    task automatic chk_vec(input logic [NUM_TRK-1:0] e,
                           input logic [NUM_TRK-1:0] a);
        check_count++;
        if (a !== e) begin
            error_cnt++;
            $display("ERROR %0t track faults: exp %b got %b", $time, e, a);
        end
    endtask
    task automatic chk_led(input encdg_led_t e, input encdg_led_t a);
        check_count++;
        if (a !== e) begin
            error_cnt++;
            $display("ERROR %0t led: exp %0d got %0d", $time, e, a);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic do_reset();
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(1'b0, uf, "reset underflow");
        chk(1'b0, of, "reset overflow");
    endtask
    // one counter sample, flags judged two edges later
    task automatic smp(input logic [CNT_W-1:0] c, input logic u,
                       input logic eu, input logic eo);
        @(posedge clock_i);
        cnt <= c;
        up <= u;
        repeat (2) @(posedge clock_i);
        #1;
        chk(eu, uf, "underflow");
        chk(eo, of, "overflow");
    endtask
    task automatic wrap_case(input logic [CNT_W-1:0] lim,
                             input logic [CNT_W-1:0] rs);
        logic [CNT_W+1:0] sp;
        logic [CNT_W-1:0] u, o;
        sp = {2'h0, lim - rs};
        u = rs + CNT_W'((sp * 2) / 3);
        o = rs + CNT_W'(sp / 3);
        rng <= {lim, rs};
        do_reset();
        smp(rs, 1'b0, 1'b0, 1'b0);
        smp(lim, 1'b0, 1'b1, 1'b0);
        smp(u, 1'b0, 1'b1, 1'b0);
        smp(u - 1, 1'b0, 1'b0, 1'b0);
        smp(lim, 1'b1, 1'b0, 1'b0);
        smp(rs, 1'b1, 1'b0, 1'b1);
        smp(o, 1'b1, 1'b0, 1'b1);
        smp(o + 1, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic idle_case();
        rng <= {LIMIT_DEFAULT, RESET_DEFAULT};
        do_reset();
        smp(RESET_DEFAULT, 1'b0, 1'b0, 1'b0);
        @(posedge clock_i);
        sel <= 1'b0;
        smp(LIMIT_DEFAULT, 1'b0, 1'b0, 1'b0);
        @(posedge clock_i);
        sel <= 1'b1;
        smp(LIMIT_DEFAULT, 1'b0, 1'b1, 1'b0);
        @(posedge clock_i);
        valid <= 1'b0;
        smp(RESET_DEFAULT, 1'b0, 1'b1, 1'b0);
        @(posedge clock_i);
        valid <= 1'b1;
        ce_i <= 1'b0;
        smp(RESET_DEFAULT, 1'b0, 1'b1, 1'b0);
        @(posedge clock_i);
        ce_i <= 1'b1;
        smp(RESET_DEFAULT, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic flt_case(input logic dif, input logic [NUM_TRK-1:0] en,
                            input logic [NUM_TRK-1:0] b);
        logic [NUM_TRK-1:0] e;
        logic [2:0]         h;
        e = (dif ? en : 3'h0) & b;
        h = '0;
        @(posedge clock_i);
        cfg <= {dif, en};
        brk <= b;
        // led shows the track A level seen two edges before the check
        repeat (6) begin
            @(posedge clock_i);
            #1;
            h = {h[1:0], lvl[TRK_A]};
        end
        chk_vec(e, flt);
        chk(|e, oc, "open circuit");
        chk(|e, inv, "data invalid");
        if (e[TRK_A])
            chk_led(ENCDG_LED_RED, led);
        else begin
            chk(1'b1, led !== ENCDG_LED_RED, "led red");
            chk_led(h[2] ? ENCDG_LED_GREEN : ENCDG_LED_OFF, led);
        end
    endtask

    initial begin
        do_reset();
        wrap_case(LIMIT_DEFAULT, RESET_DEFAULT);
        wrap_case(32'h00000FFF, 32'h00000190);
        idle_case();
        for (int i = 0; i < NUM_TRK; i++) begin
            flt_case(1'b1, 3'h7, NUM_TRK'(1 << i));
        end
        flt_case(1'b1, 3'h7, 3'h0);
        flt_case(1'b1, 3'h6, 3'h7);
        flt_case(1'b0, 3'h7, 3'h7);
        flt_case(1'b1, 3'h7, 3'h0);
        final_report();
    end

    // watchdog well beyond the roughly 150 cycles the tests need
    initial begin
        repeat (3000) @(posedge clock_i);
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
